/* File: rtl/xcrg_map.svh */
// Offsets, field positions, reset values and timing counts of the clock/reset generator
`ifndef XCRG_MAP_SVH
`define XCRG_MAP_SVH
// Clock period; the clock runs at twice the crystal rate
`define XCRG_CLK_NS 10
`define XCRG_CLK_PER_XTO 2
// Oscillator start-up time constant and the least multiple waited
`define XCRG_TAU_NS 100
`define XCRG_TAU_MIN 10
`define XCRG_START_CYC ((`XCRG_TAU_MIN * `XCRG_TAU_NS + `XCRG_CLK_NS - 1) / `XCRG_CLK_NS)
// Host clock is crystal / 3, digital tick is crystal / 16
`define XCRG_HOST_DIV 3
`define XCRG_HOST_HALF ((`XCRG_HOST_DIV * `XCRG_CLK_PER_XTO) / 2)
`define XCRG_DCLK_DIV 16
`define XCRG_DCLK_CYC (`XCRG_DCLK_DIV * `XCRG_CLK_PER_XTO)
// Register indexes
`define XCRG_ADDR_CREG1 4'h0
`define XCRG_ADDR_CREG2 4'h1
`define XCRG_ADDR_CREG3 4'h2
`define XCRG_ADDR_CREG4 4'h3
`define XCRG_ADDR_CREG6 4'h5
`define XCRG_ADDR_STATUS 4'h7
`define XCRG_ADDR_CMD 4'h8
// Reset values
`define XCRG_CREG1_RST 8'h80
`define XCRG_CREG2_RST 8'h00
`define XCRG_CREG3_RST 8'hc0
`define XCRG_CREG4_RST 8'h10
`define XCRG_CREG6_RST 8'h00
// Field positions
`define XCRG_LOW_BAND_BIT 4
`define XCRG_CLKON_BIT 7
`define XCRG_SOEN_BIT 6
`define XCRG_OFF_BIT 0
// Twice the integer-plus-half synthesizer bases
`define XCRG_BASE_LOW 8'h31
`define XCRG_BASE_MID 8'h41
`define XCRG_BASE_HIGH 8'h81
`endif

/* File: rtl/xcrg_pkg.sv */
// Types shared by the clock/reset generator
package xcrg_pkg;
    typedef enum logic [1:0]
    {
        XCRG_OFF = 2'h0,
        XCRG_START = 2'h1,
        XCRG_ON = 2'h3
    } xcrg_state_type;

    // Supply monitor flags
    typedef struct packed
    {
        logic digital_supply_good;
        logic supply_out_good;
        logic battery_low;
    } xcrg_mon_type;

    // Synthesizer setting: twice the base, and the frequency word
    typedef struct packed
    {
        logic [7:0] base_x2;
        logic [12:0] synth_frequency_word;
    } xcrg_synth_type;
endpackage

/* File: rtl/xcrg_top.sv */
// Crystal clock, host reset, tick dividers, supply flags and power-on control
`include "xcrg_map.svh"
// Summary of operation
// R1: Oscillator good after detector and 10 taus
// R2: Good oscillator releases reset, enables host clock
// R3: Load capacitors partly off in idle/sleep
// R4: RF base chosen by band bit and pin
// R5: Frequency word is sum of two parts
// R6: Host programs word 3803..4053 single channel
// R7: Host clock is crystal divided by three
// R8: Host clock 50% duty, short first cycle; the divider here restarts on enable, so its first half is full
// R9: Digital tick is crystal divided by sixteen
// R10: Baud period is tick times limit times range
// R11: Polling and baud timed from divided tick
// R12: Supply output off by bit, on at wake
// R13: Host reset low below low supply threshold
// R14: Power-on input high wakes the device
// R15: Any low button input wakes the device
// R16: Three supply monitor flags are produced
// R17: Off state ignores serial accesses entirely; the gate is registered, so the first off cycle still passes them
// R18: Internal supply reset restores register defaults
// R19: Disabled clock holds dividers clear, output low
// R20: Baud counter wraps with one-cycle pulse
module xcrg_top
    import xcrg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Analogue comparators and amplitude detector
    input wire logic amp_detect,
    input wire logic digital_supply_above,
    input wire logic supply_out_above_low,
    input wire logic supply_out_above_batt,
    input wire logic aux_above_threshold,
    // Wake pins and band select pin
    input wire logic power_on_input,
    input wire logic [4:0] wake_button_inputs_n,
    input wire logic band_pin,
    // Clocks, ticks and reset to the host
    output logic host_clock,
    output logic host_reset_n,
    output logic digital_tick,
    output logic baud_tick,
    // Status and control outputs
    output logic osc_amplitude_good,
    output logic osc_enable,
    output logic supply_output,
    output logic load_cap_connect,
    output logic serial_access_enable,
    output xcrg_mon_type mon_flags,
    output xcrg_synth_type synth
);
    xcrg_state_type state_q;
    logic [7:0] creg1_q, creg2_q, creg3_q, creg4_q, creg6_q;
    logic [7:0] start_cnt_q;
    logic [1:0] host_cnt_q;
    logic [4:0] dclk_cnt_q;
    logic [10:0] baud_cnt_q;
    logic dreset_q, wake_req, host_clk_en, tick_en, wr_ok;
    logic [10:0] baud_target;
    // Baud period in digital ticks for a range and limit
    function automatic logic [10:0] baud_len(input logic [1:0] range, input logic [7:0] limit);
        case (range)
            2'h0: baud_len = {limit, 3'h0};
            2'h1: baud_len = {1'h0, limit, 2'h0};
            2'h2: baud_len = {2'h0, limit, 1'h0};
            default: baud_len = {3'h0, limit};
        endcase
    endfunction
    assign wake_req = power_on_input | ~(&wake_button_inputs_n) | aux_above_threshold; // R14 R15
    assign host_clk_en = osc_amplitude_good & mon_flags.supply_out_good
        & creg3_q[`XCRG_CLKON_BIT] & ~dreset_q; // R2
    assign tick_en = osc_amplitude_good & ~dreset_q;
    assign wr_ok = reg_write & serial_access_enable; // R17
    assign baud_target = baud_len(creg6_q[1:0], creg4_q);
    // Power state: off until a wake request, back off on command
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            state_q <= XCRG_OFF;
        else
            case (state_q)
                XCRG_OFF:
                    if (wake_req) // R14 R15
                        state_q <= XCRG_START;
                XCRG_START:
                    if (osc_amplitude_good)
                        state_q <= XCRG_ON;
                XCRG_ON:
                    // An off command is refused while any wake source is still asserted
                    if (wr_ok && reg_addr == `XCRG_ADDR_CMD && reg_wdata[`XCRG_OFF_BIT]
                        && !wake_req)
                        state_q <= XCRG_OFF; // R17
                default:
                    state_q <= XCRG_OFF;
            endcase
    end
    // Internal supply reset: off, digital supply low, or supply drop while enabled
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            dreset_q <= 1'b1;
        else
            dreset_q <= state_q == XCRG_OFF || !digital_supply_above
                || (!supply_out_above_low && creg3_q[`XCRG_SOEN_BIT]); // R18
    end
    // Oscillator enable and start-up wait
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_enable <= 1'b0;
            start_cnt_q <= 8'h00;
            osc_amplitude_good <= 1'b0;
        end
        else
        begin
            osc_enable <= state_q != XCRG_OFF;
            if (!osc_enable)
                start_cnt_q <= 8'h00;
            else if (start_cnt_q < 8'(`XCRG_START_CYC))
                start_cnt_q <= start_cnt_q + 8'h01;
            // Detector alone is not trusted before ten time constants
            osc_amplitude_good <= osc_enable && amp_detect
                && start_cnt_q >= 8'(`XCRG_START_CYC); // R1
        end
    end
    // Control registers, defaults restored by the internal supply reset
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            creg1_q <= `XCRG_CREG1_RST;
            creg2_q <= `XCRG_CREG2_RST;
            creg3_q <= `XCRG_CREG3_RST;
            creg4_q <= `XCRG_CREG4_RST;
            creg6_q <= `XCRG_CREG6_RST;
        end
        else if (dreset_q)
        begin
            creg1_q <= `XCRG_CREG1_RST; // R18
            creg2_q <= `XCRG_CREG2_RST;
            creg3_q <= `XCRG_CREG3_RST;
            creg4_q <= `XCRG_CREG4_RST;
            creg6_q <= `XCRG_CREG6_RST;
        end
        else if (wr_ok)
            case (reg_addr)
                `XCRG_ADDR_CREG1: creg1_q <= reg_wdata;
                `XCRG_ADDR_CREG2: creg2_q <= reg_wdata;
                `XCRG_ADDR_CREG3: creg3_q <= reg_wdata;
                `XCRG_ADDR_CREG4: creg4_q <= reg_wdata;
                `XCRG_ADDR_CREG6: creg6_q <= reg_wdata;
                default: creg1_q <= creg1_q;
            endcase
    end
    // Read port; nothing answers while serial access is off
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (!reg_read || !serial_access_enable)
            reg_rdata <= 8'h00; // R17
        else
            case (reg_addr)
                `XCRG_ADDR_CREG1: reg_rdata <= creg1_q;
                `XCRG_ADDR_CREG2: reg_rdata <= creg2_q;
                `XCRG_ADDR_CREG3: reg_rdata <= creg3_q;
                `XCRG_ADDR_CREG4: reg_rdata <= creg4_q;
                `XCRG_ADDR_CREG6: reg_rdata <= creg6_q;
                `XCRG_ADDR_STATUS: reg_rdata <= {state_q == XCRG_ON, osc_amplitude_good,
                    host_reset_n, mon_flags, supply_output, 1'b0};
                default: reg_rdata <= 8'h00;
            endcase
    end
    // Monitor flags and serial access gate
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mon_flags <= '0;
            serial_access_enable <= 1'b0;
        end
        else
        begin
            mon_flags.digital_supply_good <= digital_supply_above; // R16
            mon_flags.supply_out_good <= supply_out_above_low;
            mon_flags.battery_low <= !supply_out_above_batt;
            serial_access_enable <= state_q != XCRG_OFF && supply_out_above_low; // R17
        end
    end
    // Host reset with hysteresis: falls at 2.3 V, releases above 2.38 V
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            host_reset_n <= 1'b0;
        else if (!supply_out_above_low || !osc_amplitude_good || state_q == XCRG_OFF)
            host_reset_n <= 1'b0; // R13
        else if (supply_out_above_batt && digital_supply_above)
            host_reset_n <= 1'b1; // R2
    end
    // Supply output: bit clears it, only a wake turns it on again
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            supply_output <= 1'b0;
        else if (state_q == XCRG_OFF)
            supply_output <= wake_req; // R12
        else if (!creg3_q[`XCRG_SOEN_BIT] && !dreset_q)
            supply_output <= 1'b0; // R12
    end
    // Load capacitors: partly off in idle (00) and sleep (01)
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            load_cap_connect <= 1'b0;
        else
            load_cap_connect <= state_q == XCRG_ON && creg1_q[1]; // R3
    end
    // Synthesizer word and base
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            synth <= '0;
        else
        begin
            synth.synth_frequency_word <= {5'h00, creg2_q} + {creg3_q[4:0], 8'h00}; // R5
            if (!band_pin)
                synth.base_x2 <= `XCRG_BASE_HIGH; // R4
            else if (creg1_q[`XCRG_LOW_BAND_BIT])
                synth.base_x2 <= `XCRG_BASE_LOW;
            else
                synth.base_x2 <= `XCRG_BASE_MID;
        end
    end
    // Host clock divider; the count is held clear until enable, so the first half is a full three cycles
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            host_cnt_q <= 2'h0;
            host_clock <= 1'b0;
        end
        else if (!host_clk_en)
        begin
            host_cnt_q <= 2'h0; // R19
            host_clock <= 1'b0;
        end
        else if (host_cnt_q == 2'(`XCRG_HOST_HALF - 1))
        begin
            host_cnt_q <= 2'h0;
            host_clock <= !host_clock; // R7 R8
        end
        else
            host_cnt_q <= host_cnt_q + 2'h1;
    end
    // Digital tick divider
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            dclk_cnt_q <= 5'h00;
            digital_tick <= 1'b0;
        end
        else if (!tick_en)
        begin
            dclk_cnt_q <= 5'h00; // R19
            digital_tick <= 1'b0;
        end
        else
        begin
            dclk_cnt_q <= dclk_cnt_q + 5'h01;
            digital_tick <= dclk_cnt_q == 5'(`XCRG_DCLK_CYC - 1); // R9
        end
    end
    // Baud tick counts digital ticks; a zero limit stops it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            baud_cnt_q <= 11'h000;
            baud_tick <= 1'b0;
        end
        else if (!tick_en || baud_target == 11'h000)
        begin
            baud_cnt_q <= 11'h000; // R19
            baud_tick <= 1'b0;
        end
        else if (digital_tick)
        begin
            baud_tick <= baud_cnt_q + 11'h001 >= baud_target; // R10 R11 R20
            baud_cnt_q <= (baud_cnt_q + 11'h001 >= baud_target) ? 11'h000
                : baud_cnt_q + 11'h001; // R20
        end
        else
            baud_tick <= 1'b0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_osc_good_wait: assert property ($rose(osc_amplitude_good) // R1
        |-> $past(start_cnt_q) >= 8'(`XCRG_START_CYC) && $past(amp_detect))
        else $error("oscillator good before start-up wait");
    a_reset_needs_osc: assert property ($rose(host_reset_n) // R2
        |-> osc_amplitude_good && $past(supply_out_above_batt))
        else $error("host reset released without oscillator");
    a_reset_low_supply: assert property (!supply_out_above_low |=> !host_reset_n) // R13
        else $error("host reset not low on supply drop");
    a_host_clk_third: assert property ($rose(host_clock) && host_clk_en // R7
        ##1 host_clk_en [*5] |=> $rose(host_clock))
        else $error("host clock period not six cycles");
    a_host_clk_off: assert property (!host_clk_en |=> !host_clock && host_cnt_q == 2'h0) // R19
        else $error("host clock not held low");
    a_tick_spacing: assert property (digital_tick |=> !digital_tick [*8]) // R9
        else $error("digital tick too close");
    a_baud_pulse: assert property (baud_tick |=> !baud_tick && baud_cnt_q == 11'h000) // R20
        else $error("baud tick not one cycle or count not restarted");
    a_off_no_read: assert property (state_q == XCRG_OFF ##1 1 |=> reg_rdata == 8'h00) // R17
        else $error("read answered while off");
    a_supply_bit_off: assert property (state_q == XCRG_ON && !creg3_q[`XCRG_SOEN_BIT] // R12
        && !dreset_q |=> !supply_output)
        else $error("supply output not switched off");
    a_cap_idle: assert property (creg1_q[1:0] == 2'h0 |=> !load_cap_connect) // R3
        else $error("load capacitors connected in idle");
    a_defaults: assert property (dreset_q |=> creg3_q == `XCRG_CREG3_RST) // R18
        else $error("register defaults not restored");
    c_wake: cover property (state_q == XCRG_OFF ##1 state_q == XCRG_START);
    c_reset_release: cover property ($rose(host_reset_n));
    c_baud: cover property (baud_tick);
    c_off_cmd: cover property (state_q == XCRG_ON ##1 state_q == XCRG_OFF);
endmodule

/* File: verification/tb_xto_clock_reset_gen.sv */
// Self-checking bench for the crystal clock and reset generator
module tb_xto_clock_reset_gen
    import xcrg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic amp_detect = 1'b1;
    logic digital_supply_above = 1'b1;
    logic supply_out_above_low = 1'b1;
    logic supply_out_above_batt = 1'b1;
    logic aux_above_threshold = 1'b0;
    logic power_on_input = 1'b0;
    logic band_pin = 1'b0;
    logic [4:0] wake_button_inputs_n = 5'h1f;
    logic [7:0] reg_rdata, rd;
    logic host_clock, host_reset_n, digital_tick, baud_tick, osc_amplitude_good;
    logic osc_enable, supply_output, load_cap_connect, serial_access_enable;
    xcrg_mon_type mon_flags;
    xcrg_synth_type synth;
    int n_errors = 0;
    int n_checks = 0;
    int hi_len, lo_len, n_rise, c, g, r, i;
    wire [3:0] watch = {serial_access_enable, osc_amplitude_good, osc_enable, host_reset_n};
    localparam logic [3:0] RA [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h4};
    localparam logic [7:0] RV [6] = '{8'h80, 8'h00, 8'hc0, 8'h10, 8'h00, 8'h00};
    localparam logic BP [3] = '{1'b0, 1'b1, 1'b1};
    localparam logic [7:0] BC [3] = '{8'h80, 8'h80, 8'h92};
    localparam logic [7:0] BX [3] = '{8'h81, 8'h41, 8'h31};

    xcrg_top uut (.clock, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .amp_detect, .digital_supply_above, .supply_out_above_low, .supply_out_above_batt,
        .aux_above_threshold, .power_on_input, .wake_button_inputs_n, .band_pin, .host_clock,
        .host_reset_n, .digital_tick, .baud_tick, .osc_amplitude_good, .osc_enable,
        .supply_output, .load_cap_connect, .serial_access_enable, .mon_flags, .synth);

    xcrg_host_model host (.clock, .host_clock, .host_reset_n, .hi_len, .lo_len, .n_rise);

    // Free-running system clock
    initial
        forever #5 clock = ~clock;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Bounded wait for one watched status bit
    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        for (n = 0; n < lim && watch[b] !== v; n++)
            @(posedge clock) #1;
    endtask

    // Cycles between two pulses of the digital or baud tick
    task automatic pulse_gap(input bit sel, input int lim, output int gap);
        int n;
        int k;
        bit seen;
        seen = 0;
        gap = 0;
        k = 0;
        for (n = 0; n < lim && gap == 0; n++)
        begin
            @(posedge clock) #1;
            k++;
            if ((sel ? baud_tick : digital_tick) === 1'b1)
            begin
                if (seen)
                    gap = k;
                seen = 1;
                k = 0;
            end
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock) #1;
        check("off state", watch, 4'h0);
        rd_reg(4'h0, rd);
        check("off read", rd, 8'h00);
        power_on_input <= 1'b1;
        wait_bit(1, 1'b1, 10, c);
        wait_bit(2, 1'b1, 300, c);
        check("osc start", (c >= 99) && (c <= 110), 1'b1);
        wait_bit(0, 1'b1, 10, c);
        check("host reset", host_reset_n, 1'b1);
        for (i = 0; i < 6; i++)
        begin
            rd_reg(RA[i], rd);
            check("default", rd, RV[i]);
        end
        rd_reg(4'h7, rd);
        check("status", rd, 8'hfa);
        repeat (30) @(posedge clock);
        check("clock high", hi_len, 3);
        check("clock low", lo_len, 3);
        pulse_gap(0, 100, g);
        check("tick", g, 32);
        wr(4'h3, 8'h03);
        for (r = 0; r < 4; r++)
        begin
            wr(4'h5, r[7:0]);
            pulse_gap(1, 3000, g);
            pulse_gap(1, 3000, g);
            check("baud", g, 32 * 3 * (8 >> r));
        end
        // Word 3900 sits inside the recommended single-channel span
        wr(4'h1, 8'h3c);
        wr(4'h2, 8'hcf);
        repeat (2) @(posedge clock) #1;
        check("word", synth.synth_frequency_word, 13'hf3c);
        for (i = 0; i < 3; i++)
        begin
            band_pin <= BP[i];
            wr(4'h0, BC[i]);
            repeat (2) @(posedge clock) #1;
            check("base", synth.base_x2, BX[i]);
            check("load caps", load_cap_connect, BC[i][1]);
        end
        wr(4'h2, 8'h4f);
        repeat (3) @(posedge clock);
        g = n_rise;
        repeat (12) @(posedge clock) #1;
        check("clock held", {host_clock, n_rise == g}, 2'b01);
        wr(4'h2, 8'h8f);
        repeat (3) @(posedge clock) #1;
        check("supply off", supply_output, 1'b0);
        supply_out_above_batt <= 1'b0;
        repeat (3) @(posedge clock) #1;
        check("monitors", {mon_flags, host_reset_n}, 4'hf);
        supply_out_above_low <= 1'b0;
        repeat (3) @(posedge clock) #1;
        check("low supply", {host_reset_n, serial_access_enable}, 2'b00);
        supply_out_above_low <= 1'b1;
        supply_out_above_batt <= 1'b1;
        repeat (4) @(posedge clock);
        rd_reg(4'h1, rd);
        check("kept word", {rd, supply_output}, 9'h078);
        power_on_input <= 1'b0;
        wr(4'h8, 8'h01);
        // Oscillator good falls one cycle after the oscillator enable
        wait_bit(2, 1'b0, 10, c);
        check("off cmd", watch, 4'h0);
        // No amplitude on the first wake: the start-up count alone must not pass
        amp_detect <= 1'b0;
        for (i = 0; i < 5; i++)
        begin
            wake_button_inputs_n <= ~(5'h01 << i);
            wait_bit(3, 1'b1, 20, c);
            check("button wake", {osc_enable, supply_output}, 2'b11);
            wake_button_inputs_n <= 5'h1f;
            if (i == 0)
            begin
                repeat (120) @(posedge clock) #1;
                check("no amplitude", osc_amplitude_good, 1'b0);
                amp_detect <= 1'b1;
            end
            // The off command is only taken once fully on
            wait_bit(0, 1'b1, 200, c);
            rd_reg(4'h1, rd);
            check("wake default", rd, 8'h00);
            wr(4'h8, 8'h01);
            wait_bit(2, 1'b0, 10, c);
            check("off again", watch, 4'h0);
        end
        // Auxiliary supply alone is a wake source too
        aux_above_threshold <= 1'b1;
        wait_bit(3, 1'b1, 20, c);
        check("aux wake", {osc_enable, serial_access_enable}, 2'b11);
        digital_supply_above <= 1'b0;
        repeat (3) @(posedge clock) #1;
        check("digital supply", {mon_flags.digital_supply_good, host_reset_n}, 2'b00);
        conclude();
    end

    // Whole run needs well under ten thousand cycles
    initial
    begin
        #500000;
        n_errors++;
        conclude();
    end
endmodule

/* File: verification/xcrg_host_model.sv */
// Host microcontroller model that measures the clock and reset it is given
module xcrg_host_model
(
    // System clock and the host's own pins
    input wire logic clock,
    input wire logic host_clock,
    input wire logic host_reset_n,
    // Last whole half periods in system clocks, and rising edges seen while host reset is released
    output int hi_len,
    output int lo_len,
    output int n_rise
);
    timeunit 1ns;
    timeprecision 1ns;

    int run = 0;
    logic last = 1'b0;

    // Each half period is timed; a short first cycle only shows up once
    always @(posedge clock)
    begin
        if (host_clock !== last)
        begin
            if (host_clock === 1'b1)
            begin
                lo_len <= run;
                n_rise <= n_rise + ((host_reset_n === 1'b1) ? 1 : 0);
            end
            else
                hi_len <= run;
            run <= 1;
        end
        else
            run <= run + 1;
        last <= host_clock;
    end
endmodule
